// ### src/vasb_regs.svh
// Purpose: Register indices, field positions, reset values and widths of the voltage alert status bank.
// Assumes: Each register index maps to byte address index * 4 on the register bus.
// Notes:   Definitions only.
`ifndef VASB_REGS_SVH
`define VASB_REGS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define VASB_AUX_W        6
`define VASB_CELL_W       14
`define VASB_ADDR_W       8
`define VASB_IRQ_W        3

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define VASB_IDX_AUX_HIGH      6'h0c
`define VASB_IDX_AUX_LOW       6'h0d
`define VASB_IDX_CMP_CELL_HIGH 6'h0e
`define VASB_IDX_CMP_CELL_LOW  6'h0f
`define VASB_IDX_CMP_AUX_HIGH  6'h10
`define VASB_IDX_AUX_ENABLE    6'h20
`define VASB_IDX_CELL_HIGH_EN  6'h21
`define VASB_IDX_CELL_LOW_EN   6'h22
`define VASB_IDX_IRQ_STATUS    6'h23
`define VASB_IDX_IRQ_ENABLE    6'h24
`define VASB_IDX_IRQ_CLEAR     6'h25

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define VASB_AUX_LOW_EN_LSB    8
`define VASB_IRQ_ADC_DONE      0
`define VASB_IRQ_CMP_DONE      1
`define VASB_IRQ_ALERT_RISE    2
`define VASB_FLAG_RESET        16'h0000
`define VASB_RESP_OKAY         2'h0
`define VASB_RESP_DECERR       2'h3

`endif

// ### src/vasb_pkg.sv
// Purpose: Types shared by the voltage alert status bank and its surroundings.
// Assumes: Widths come from vasb_regs.svh.
// Notes:   AXI4-Lite field names stay as published.
`include "vasb_regs.svh"

package vasb_pkg;

  // --------------------------------------------------------------------------
  // Register bus carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`VASB_ADDR_W-1:0] awaddr;
    logic                    awvalid;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    wvalid;
    logic                    bready;
    logic [`VASB_ADDR_W-1:0] araddr;
    logic                    arvalid;
    logic                    rready;
  } vasb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } vasb_axi_rsp_t;

  // --------------------------------------------------------------------------
  // Acquisition results
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`VASB_AUX_W-1:0] aux_over;
    logic [`VASB_AUX_W-1:0] aux_under;
  } vasb_adc_res_t;

  typedef struct packed {
    logic [`VASB_CELL_W-1:0] cell_over;
    logic [`VASB_CELL_W-1:0] cell_under;
    logic [`VASB_AUX_W-1:0]  aux_over;
  } vasb_cmp_res_t;

endpackage

// ### src/vasb_bank.sv
// Purpose: Read-only alert status bank with alert enables and an interrupt, on AXI4-Lite.
// Assumes: Acquisition results and done strobes come from logic on aclk; no synchroniser needed.
// Notes:   All state sits in one packed struct, registered once.
//
// How it works
// - An enabled auxiliary input above the cold threshold on a main converter acquisition sets its high flag.
// - That auxiliary high flag clears at the next main acquisition without the condition or when its enable is cleared, else it holds.
// - An enabled auxiliary input below the hot threshold on a main converter acquisition sets its low flag.
// - That auxiliary low flag clears at the next main acquisition in which the condition is gone.
// - An enabled cell above the comparator high threshold sets its comparator cell high flag in bits 13:0.
// - Comparator high flags for cells and auxiliary inputs clear at a comparator acquisition without the fault, or when their enable is cleared.
// - An enabled cell below the comparator low threshold sets its comparator cell low flag.
// - Comparator cell low flags clear at the next comparator acquisition in which the condition is gone.
// - An enabled auxiliary input above the comparator cold threshold sets its comparator auxiliary high flag.
// - The flag registers are readable and ignore writes to them; they change on acquisitions and drop when an enable write clears their enable.
`timescale 1ns/1ps
`include "vasb_regs.svh"

module vasb_bank #(
  parameter int AUX_N  = `VASB_AUX_W,
  parameter int CELL_N = `VASB_CELL_W
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire vasb_pkg::vasb_axi_req_t axi_req,
  output vasb_pkg::vasb_axi_rsp_t      axi_rsp,
  input  wire vasb_pkg::vasb_adc_res_t adc_res,
  input  wire logic                    adc_done,
  input  wire vasb_pkg::vasb_cmp_res_t cmp_res,
  input  wire logic                    cmp_done,
  output logic                         irq
);
  import vasb_pkg::*;

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  // The carriers are fixed in width, so other channel counts cannot be served.
  if (AUX_N != `VASB_AUX_W || CELL_N != `VASB_CELL_W)
  begin : g_bad_width
    $error("vasb_bank: channel counts must match the carrier widths");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                    aw_got;
    logic [`VASB_ADDR_W-1:0] awaddr;
    logic                    w_got;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic [AUX_N-1:0]        aux_hi;
    logic [AUX_N-1:0]        aux_lo;
    logic [CELL_N-1:0]       cell_hi;
    logic [CELL_N-1:0]       cell_lo;
    logic [AUX_N-1:0]        caux_hi;
    logic [AUX_N-1:0]        aux_hi_en;
    logic [AUX_N-1:0]        aux_lo_en;
    logic [CELL_N-1:0]       cell_hi_en;
    logic [CELL_N-1:0]       cell_lo_en;
    logic [`VASB_IRQ_W-1:0]  irq_stat;
    logic [`VASB_IRQ_W-1:0]  irq_en;
    logic                    irq;
  } vasb_state_t;

  localparam vasb_state_t ST_RESET = '0;

  vasb_state_t            st_reg;
  vasb_state_t            st_next;
  logic                   do_wr;
  logic [5:0]             widx;
  logic [5:0]             ridx;
  logic [31:0]            wmask;
  logic [31:0]            wval;
  logic [31:0]            rd_data;
  logic                   rd_hit;
  logic [`VASB_IRQ_W-1:0] irq_set;
  logic [`VASB_IRQ_W-1:0] irq_clr;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    irq_set = '0;
    irq_clr = '0;
    widx    = st_reg.awaddr[7:2];
    ridx    = axi_req.araddr[7:2];
    wmask   = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}}, {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
    wval    = st_reg.wdata & wmask;
    do_wr   = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;

    // Write address and data are taken in either order.
    if (axi_req.awvalid && st_reg.awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_reg.wready)
    begin
      st_next.w_got = 1'b1;
      st_next.wdata = axi_req.wdata;
      st_next.wstrb = axi_req.wstrb;
    end
    if (st_reg.bvalid && axi_req.bready)
    begin
      st_next.bvalid = 1'b0;
    end

    // Only the enable, interrupt enable and interrupt clear registers accept data; flag and interrupt status writes are ignored.
    if (do_wr)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = `VASB_RESP_OKAY;
      case (widx)
        `VASB_IDX_AUX_HIGH, `VASB_IDX_AUX_LOW, `VASB_IDX_CMP_CELL_HIGH,
        `VASB_IDX_CMP_CELL_LOW, `VASB_IDX_CMP_AUX_HIGH, `VASB_IDX_IRQ_STATUS:
        begin
          st_next.bresp = `VASB_RESP_OKAY;
        end
        `VASB_IDX_AUX_ENABLE:
        begin
          st_next.aux_hi_en = (st_reg.aux_hi_en & ~wmask[AUX_N-1:0]) | wval[AUX_N-1:0];
          st_next.aux_lo_en = (st_reg.aux_lo_en & ~wmask[`VASB_AUX_LOW_EN_LSB +: AUX_N])
                            | wval[`VASB_AUX_LOW_EN_LSB +: AUX_N];
        end
        `VASB_IDX_CELL_HIGH_EN:
        begin
          st_next.cell_hi_en = (st_reg.cell_hi_en & ~wmask[CELL_N-1:0]) | wval[CELL_N-1:0];
        end
        `VASB_IDX_CELL_LOW_EN:
        begin
          st_next.cell_lo_en = (st_reg.cell_lo_en & ~wmask[CELL_N-1:0]) | wval[CELL_N-1:0];
        end
        `VASB_IDX_IRQ_ENABLE:
        begin
          st_next.irq_en = (st_reg.irq_en & ~wmask[`VASB_IRQ_W-1:0]) | wval[`VASB_IRQ_W-1:0];
        end
        `VASB_IDX_IRQ_CLEAR:
        begin
          irq_clr = wval[`VASB_IRQ_W-1:0];
        end
        default:
        begin
          st_next.bresp = `VASB_RESP_DECERR;
        end
      endcase
    end

    // Read decode; flag registers pad their unused upper bits with zero.
    case (ridx)
      `VASB_IDX_AUX_HIGH:      rd_data = {{(32-AUX_N){1'b0}}, st_reg.aux_hi};
      `VASB_IDX_AUX_LOW:       rd_data = {{(32-AUX_N){1'b0}}, st_reg.aux_lo};
      `VASB_IDX_CMP_CELL_HIGH: rd_data = {{(32-CELL_N){1'b0}}, st_reg.cell_hi};
      `VASB_IDX_CMP_CELL_LOW:  rd_data = {{(32-CELL_N){1'b0}}, st_reg.cell_lo};
      `VASB_IDX_CMP_AUX_HIGH:  rd_data = {{(32-AUX_N){1'b0}}, st_reg.caux_hi};
      `VASB_IDX_AUX_ENABLE:
        rd_data = {{(32-`VASB_AUX_LOW_EN_LSB-AUX_N){1'b0}}, st_reg.aux_lo_en,
                   {(`VASB_AUX_LOW_EN_LSB-AUX_N){1'b0}}, st_reg.aux_hi_en};
      `VASB_IDX_CELL_HIGH_EN:  rd_data = {{(32-CELL_N){1'b0}}, st_reg.cell_hi_en};
      `VASB_IDX_CELL_LOW_EN:   rd_data = {{(32-CELL_N){1'b0}}, st_reg.cell_lo_en};
      `VASB_IDX_IRQ_STATUS:    rd_data = {{(32-`VASB_IRQ_W){1'b0}}, st_reg.irq_stat};
      `VASB_IDX_IRQ_ENABLE:    rd_data = {{(32-`VASB_IRQ_W){1'b0}}, st_reg.irq_en};
      `VASB_IDX_IRQ_CLEAR:     rd_data = 32'h0000_0000;
      default:                 rd_hit  = 1'b0;
    endcase

    if (st_reg.rvalid && axi_req.rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_data;
      st_next.rresp  = rd_hit ? `VASB_RESP_OKAY : `VASB_RESP_DECERR;
    end

    // Flags load results only on their own acquisition strobe and are masked by enables.
    if (adc_done)
    begin
      st_next.aux_hi = adc_res.aux_over;
      st_next.aux_lo = adc_res.aux_under;
    end
    if (cmp_done)
    begin
      st_next.cell_hi = cmp_res.cell_over;
      st_next.cell_lo = cmp_res.cell_under;
      st_next.caux_hi = cmp_res.aux_over;
    end
    // Masking every cycle means a flag also drops as soon as software disables it.
    st_next.aux_hi  = st_next.aux_hi & st_next.aux_hi_en;
    st_next.aux_lo  = st_next.aux_lo & st_next.aux_lo_en;
    st_next.cell_hi = st_next.cell_hi & st_next.cell_hi_en;
    st_next.cell_lo = st_next.cell_lo & st_next.cell_lo_en;
    st_next.caux_hi = st_next.caux_hi & st_next.aux_hi_en;

    // Interrupt events; a new event wins over a clear in the same cycle.
    irq_set[`VASB_IRQ_ADC_DONE]   = adc_done;
    irq_set[`VASB_IRQ_CMP_DONE]   = cmp_done;
    irq_set[`VASB_IRQ_ALERT_RISE] = |{st_next.aux_hi & ~st_reg.aux_hi, st_next.aux_lo & ~st_reg.aux_lo,
                                      st_next.cell_hi & ~st_reg.cell_hi, st_next.cell_lo & ~st_reg.cell_lo,
                                      st_next.caux_hi & ~st_reg.caux_hi};
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_set;
    st_next.irq      = |(st_next.irq_stat & st_next.irq_en);

    st_next.awready = !st_next.aw_got;
    st_next.wready  = !st_next.w_got;
    st_next.arready = !st_next.rvalid;
  end

  // --------------------------------------------------------------------------
  // Register
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= ST_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign axi_rsp.awready = st_reg.awready;
  assign axi_rsp.wready  = st_reg.wready;
  assign axi_rsp.bvalid  = st_reg.bvalid;
  assign axi_rsp.bresp   = st_reg.bresp;
  assign axi_rsp.arready = st_reg.arready;
  assign axi_rsp.rvalid  = st_reg.rvalid;
  assign axi_rsp.rdata   = st_reg.rdata;
  assign axi_rsp.rresp   = st_reg.rresp;
  assign irq             = st_reg.irq;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  chk_aux_high_update: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_done |=> st_reg.aux_hi == ($past(adc_res.aux_over) & st_reg.aux_hi_en))
    else $error("aux high flags wrong after main acquisition");

  chk_aux_high_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !adc_done |=> st_reg.aux_hi == ($past(st_reg.aux_hi) & st_reg.aux_hi_en))
    else $error("aux high flags changed without main acquisition");

  chk_aux_low_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_done |=> st_reg.aux_lo == ($past(adc_res.aux_under) & st_reg.aux_lo_en))
    else $error("aux low flags wrong after main acquisition");

  chk_aux_low_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !adc_done |=> st_reg.aux_lo == ($past(st_reg.aux_lo) & st_reg.aux_lo_en))
    else $error("aux low flags changed without main acquisition");

  chk_cell_high_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_done |=> st_reg.cell_hi == ($past(cmp_res.cell_over) & st_reg.cell_hi_en))
    else $error("cell high flags wrong after comparator acquisition");

  chk_cmp_high_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmp_done |=> (st_reg.cell_hi & ~$past(st_reg.cell_hi)) == '0 && (st_reg.caux_hi & ~$past(st_reg.caux_hi)) == '0)
    else $error("comparator high flags rose without comparator acquisition");

  chk_cell_low_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_done |=> st_reg.cell_lo == ($past(cmp_res.cell_under) & st_reg.cell_lo_en))
    else $error("cell low flags wrong after comparator acquisition");

  chk_cell_low_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmp_done |=> st_reg.cell_lo == ($past(st_reg.cell_lo) & st_reg.cell_lo_en))
    else $error("cell low flags changed without comparator acquisition");

  chk_cmp_aux_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_done |=> st_reg.caux_hi == ($past(cmp_res.aux_over) & st_reg.aux_hi_en))
    else $error("comparator aux high flags wrong after comparator acquisition");

  chk_flag_read_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    (axi_req.arvalid && st_reg.arready && axi_req.araddr[7:2] >= `VASB_IDX_AUX_HIGH
     && axi_req.araddr[7:2] <= `VASB_IDX_CMP_AUX_HIGH) |=> st_reg.rvalid && st_reg.rdata[31:14] == '0)
    else $error("flag read shows nonzero upper bits");

  chk_write_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && !adc_done && !cmp_done) |=> st_reg.bvalid && (st_reg.aux_hi & ~$past(st_reg.aux_hi)) == '0
      && (st_reg.cell_lo & ~$past(st_reg.cell_lo)) == '0)
    else $error("register write raised an alert flag");

  chk_enable_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.aux_hi & ~st_reg.aux_hi_en) == '0 && (st_reg.cell_lo & ~st_reg.cell_lo_en) == '0
      && (st_reg.caux_hi & ~st_reg.aux_hi_en) == '0)
    else $error("disabled alert flag is set");

  chk_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (adc_done && st_reg.irq_en[`VASB_IRQ_ADC_DONE]) |=> irq)
    else $error("interrupt missing after enabled acquisition event");

  chk_cell_high_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmp_done |=> st_reg.cell_hi == ($past(st_reg.cell_hi) & st_reg.cell_hi_en))
    else $error("cell high flags changed without comparator acquisition");

  chk_cmp_aux_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmp_done |=> st_reg.caux_hi == ($past(st_reg.caux_hi) & st_reg.aux_hi_en))
    else $error("comparator aux high flags changed without comparator acquisition");

  chk_flags_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> {st_reg.aux_hi, st_reg.aux_lo, st_reg.cell_hi, st_reg.cell_lo, st_reg.caux_hi} == '0)
    else $error("alert flags not zero after reset");

  chk_mask_low_cell: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.aux_lo & ~st_reg.aux_lo_en) == '0 && (st_reg.cell_hi & ~st_reg.cell_hi_en) == '0)
    else $error("disabled aux low or cell high flag is set");

  chk_flag_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && widx >= `VASB_IDX_AUX_HIGH && widx <= `VASB_IDX_CMP_AUX_HIGH)
      |=> st_reg.bvalid && st_reg.bresp == `VASB_RESP_OKAY)
    else $error("write to a flag register not answered OKAY");

  chk_write_resp_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.bvalid && axi_req.bready) |=> !st_reg.bvalid)
    else $error("write response not released after handshake");

  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (axi_req.arvalid && st_reg.arready) |=> st_reg.rvalid && !st_reg.arready)
    else $error("read request not answered in the next cycle");

  chk_read_resp_done: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_reg.rvalid && axi_req.rready) |=> !st_reg.rvalid && st_reg.arready)
    else $error("read response not released after handshake");

  chk_irq_event_set: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_done |=> st_reg.irq_stat[`VASB_IRQ_ADC_DONE])
    else $error("acquisition event did not set interrupt status");

endmodule

// ### testbench/tb.sv
// Purpose: Self-checking bench for the voltage alert status bank over AXI4-Lite.
// Assumes: Register byte address is index * 4; results are sampled with their one-cycle done pulse.
// Notes:   Expected values are worked out here as result and enable; none is read back from the design.
`timescale 1ns/1ps

module tb;
  import vasb_pkg::*;

  logic          aclk;
  logic          aresetn;
  vasb_axi_req_t req;
  vasb_axi_rsp_t rsp;
  vasb_adc_res_t adc_res;
  logic          adc_done;
  vasb_cmp_res_t cmp_res;
  logic          cmp_done;
  logic          irq;
  int            n_mismatch;
  int            n_checks;
  logic [31:0]   rd;
  logic [1:0]    rs;

  vasb_bank dut_u (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .axi_req  (req),
    .axi_rsp  (rsp),
    .adc_res  (adc_res),
    .adc_done (adc_done),
    .cmp_res  (cmp_res),
    .cmp_done (cmp_done),
    .irq      (irq)
  );

  always #5 aclk = ~aclk;

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Address and data are offered together; each is held until its own ready is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic got;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 100 && !got; n++)
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid)
      begin
        got = 1'b1;
        rs = rsp.bresp;
        req.bready <= 1'b0;
      end
    end
    check("write answer", {31'h0, got}, 32'h1);
    @(posedge aclk);
  endtask

  task automatic rdt(input logic [7:0] a);
    int   n;
    logic got;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 100 && !got; n++)
    begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid)
      begin
        got = 1'b1;
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
      end
    end
    check("read answer", {31'h0, got}, 32'h1);
    @(posedge aclk);
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    rdt(a);
    check(name, rd, exp);
    check("read response", {30'h0, rs}, {30'h0, resp});
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    wr(a, d);
    check("write response", {30'h0, rs}, {30'h0, resp});
  endtask

  task automatic adc_acq(input logic [5:0] o, input logic [5:0] u);
    adc_res.aux_over  <= o;
    adc_res.aux_under <= u;
    adc_done          <= 1'b1;
    @(posedge aclk);
    adc_done <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic cmp_acq(input logic [13:0] co, input logic [13:0] cu, input logic [5:0] ao);
    cmp_res.cell_over  <= co;
    cmp_res.cell_under <= cu;
    cmp_res.aux_over   <= ao;
    cmp_done           <= 1'b1;
    @(posedge aclk);
    cmp_done <= 1'b0;
    @(posedge aclk);
  endtask

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  // Enables chosen as partial masks so that a missing mask shows in the flags.
  localparam logic [5:0]  AUX_HI_EN = 6'h0f;
  localparam logic [5:0]  AUX_LO_EN = 6'h3c;
  localparam logic [13:0] CELL_LO_EN = 14'h1555;

  initial
  begin
    aclk       = 1'b0;
    aresetn    = 1'b0;
    req        = '0;
    adc_res    = '0;
    adc_done   = 1'b0;
    cmp_res    = '0;
    cmp_done   = 1'b0;
    n_mismatch = 0;
    n_checks   = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++)
      rchk("flag reset", 8'h30 + 8'(i * 4), 32'h0, 2'h0);
    rchk("unmapped read", 8'hfc, 32'h0, 2'h3);
    wchk(8'hfc, 32'hffff_ffff, 2'h3);
    wchk(8'h80, {18'h0, AUX_LO_EN, 2'h0, AUX_HI_EN}, 2'h0);
    wchk(8'h84, 32'h0000_3fff, 2'h0);
    wchk(8'h88, {18'h0, CELL_LO_EN}, 2'h0);
    rchk("aux enable readback", 8'h80, {18'h0, AUX_LO_EN, 2'h0, AUX_HI_EN}, 2'h0);
    rchk("cell high enable readback", 8'h84, 32'h0000_3fff, 2'h0);
    rchk("cell low enable readback", 8'h88, {18'h0, CELL_LO_EN}, 2'h0);
    adc_acq(6'h3a, 6'h27);
    rchk("aux high flags", 8'h30, {26'h0, 6'h3a & AUX_HI_EN}, 2'h0);
    rchk("aux low flags", 8'h34, {26'h0, 6'h27 & AUX_LO_EN}, 2'h0);
    rchk("irq status", 8'h8c, 32'h5, 2'h0);
    wchk(8'h90, 32'h2, 2'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    wchk(8'h90, 32'h5, 2'h0);
    check("irq raised", {31'h0, irq}, 32'h1);
    wchk(8'h94, 32'h5, 2'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rchk("irq status cleared", 8'h8c, 32'h0, 2'h0);
    wchk(8'h30, 32'hffff_ffff, 2'h0);
    rchk("aux high after write", 8'h30, 32'h0a, 2'h0);
    adc_res <= '0;
    repeat (3) @(posedge aclk);
    rchk("aux high held", 8'h30, 32'h0a, 2'h0);
    cmp_acq(14'h3fff, 14'h3ffe, 6'h3f);
    rchk("cmp cell high flags", 8'h38, 32'h0000_3fff, 2'h0);
    rchk("cmp cell low flags", 8'h3c, {18'h0, 14'h3ffe & CELL_LO_EN}, 2'h0);
    rchk("cmp aux high flags", 8'h40, {26'h0, AUX_HI_EN}, 2'h0);
    rchk("irq status after cmp", 8'h8c, 32'h6, 2'h0);
    rchk("irq enable readback", 8'h90, 32'h5, 2'h0);
    check("irq on alert rise", {31'h0, irq}, 32'h1);
    adc_acq(6'h00, 6'h00);
    rchk("aux high cleared", 8'h30, 32'h0, 2'h0);
    rchk("aux low cleared", 8'h34, 32'h0, 2'h0);
    rchk("cmp aux high kept", 8'h40, {26'h0, AUX_HI_EN}, 2'h0);
    rchk("cmp cell high kept", 8'h38, 32'h0000_3fff, 2'h0);
    adc_acq(6'h02, 6'h10);
    rchk("aux high partial", 8'h30, 32'h02, 2'h0);
    rchk("aux low partial", 8'h34, 32'h10, 2'h0);
    cmp_acq(14'h0000, 14'h0001, 6'h00);
    rchk("cmp cell high cleared", 8'h38, 32'h0, 2'h0);
    rchk("cmp cell low partial", 8'h3c, 32'h1, 2'h0);
    rchk("cmp aux high cleared", 8'h40, 32'h0, 2'h0);
    wchk(8'h88, 32'h0, 2'h0);
    rchk("cell low disabled", 8'h3c, 32'h0, 2'h0);
    wchk(8'h80, 32'h0, 2'h0);
    rchk("aux high disabled", 8'h30, 32'h0, 2'h0);
    rchk("aux low disabled", 8'h34, 32'h0, 2'h0);
    end_sim();
  end

  // Last-resort limit; a hung handshake already ends its task after 100 cycles, and the tests take well under a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_sim();
  end

endmodule
